/* File: pkg/sdp_regs.svh */
`ifndef SDP_REGS_SVH
`define SDP_REGS_SVH

// Clock rate and nonvolatile write time
`define SDP_CLK_KHZ 40000
`define SDP_NV_WRITE_MS 10
`define SDP_NV_WRITE_CYC (`SDP_NV_WRITE_MS * `SDP_CLK_KHZ)

// Identification byte layout
`define SDP_ID_TYPE_MSB 7
`define SDP_ID_TYPE_LSB 4
`define SDP_ID_ADDR_BIT 1
`define SDP_ID_RW_BIT 0

// Instruction byte layout
`define SDP_OP_MSB 7
`define SDP_OP_LSB 5
`define SDP_SEL_MSB 1
`define SDP_SEL_LSB 0

// Device type code: arbitrary neutral value
`define SDP_TYPE_CODE 4'h9

// Reset and power-up values
`define SDP_WIPER_RST 10'h000
`define SDP_STORE_INIT 10'h200
`define SDP_DEFAULT_SLOT 2'h0

// Last bit index of a byte and of a data word
`define SDP_BYTE_LAST 4'h7
`define SDP_WORD_LAST 4'hf

`endif

/* File: pkg/sdp_pkg.sv */
package sdp_pkg;

  // Gray coded along boot -> load -> idle -> id -> instr -> data -> skip
  typedef enum logic [2:0]
  {
    ST_BOOT  = 3'h5,
    ST_LOAD  = 3'h4,
    ST_IDLE  = 3'h0,
    ST_ID    = 3'h1,
    ST_INSTR = 3'h3,
    ST_DATA  = 3'h2,
    ST_SKIP  = 3'h6
  } sdp_state_type;

  // Instruction opcodes
  typedef enum logic [2:0]
  {
    OP_NOP0     = 3'h0,
    OP_NOP1     = 3'h1,
    OP_XFR      = 3'h2,
    OP_RD_STAT  = 3'h3,
    OP_RD_WIPER = 3'h4,
    OP_WR_WIPER = 3'h5,
    OP_RD_STORE = 3'h6,
    OP_WR_STORE = 3'h7
  } sdp_op_type;

  // Serial pins and straps as seen at the device boundary
  typedef struct packed
  {
    logic cs_n;
    logic sck;
    logic si;
    logic hold_n;
    logic wp_n;
    logic address_strap;
  } sdp_pins_type;

endpackage

/* File: rtl/sdp_store_mem.sv */
`include "sdp_regs.svh"
// Four stored position slots; read data comes out of a register
module sdp_store_mem #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4,
  parameter int AW = 2,
  parameter logic [WIDTH-1:0] INIT = `SDP_STORE_INIT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [WIDTH-1:0] rdata_q;
  logic [WIDTH-1:0] rdata_d;

  // Next contents; a write and a read of the same slot return the old word
  always_comb
  begin
    mem_d = mem_q;
    if (we)
    begin
      mem_d[waddr] = wdata;
    end
    rdata_d = mem_q[raddr];
  end

  // Reset stands in for the contents kept over power-down
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_q[i] <= INIT;
      end
      rdata_q <= '0;
    end
    else
    begin
      mem_q <= mem_d;
      rdata_q <= rdata_d;
    end
  end

  assign rdata = rdata_q;

endmodule

/* File: rtl/sdp_spi_pot.sv */
`include "sdp_regs.svh"
module sdp_spi_pot #(
  parameter int WIPER_W = 10,
  parameter int TAPS = 1024,
  parameter int NV_WRITE_CYCLES = `SDP_NV_WRITE_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire sdp_pkg::sdp_pins_type pins,
  output logic so,
  output logic so_oe,
  output logic [WIPER_W-1:0] wiper_position_reg,
  output logic [TAPS-1:0] tap_select,
  output logic write_pending_flag,
  output logic standby,
  output logic active
);

  localparam int NVW = $clog2(NV_WRITE_CYCLES + 1);
  localparam sdp_pkg::sdp_pins_type PINS_RST = '{cs_n: 1'h1, sck: 1'h0, si: 1'h0,
                                                 hold_n: 1'h1, wp_n: 1'h1, address_strap: 1'h0};

  // Read opcodes need the direction bit set, the others need it clear
  function automatic logic is_read(input sdp_pkg::sdp_op_type op);
    is_read = (op == sdp_pkg::OP_RD_STAT) || (op == sdp_pkg::OP_RD_WIPER) ||
              (op == sdp_pkg::OP_RD_STORE);
  endfunction

  sdp_pkg::sdp_pins_type pins_s1_q;
  sdp_pkg::sdp_pins_type pins_s2_q;
  logic sck_s3_q;
  logic cs_s3_q;
  logic sck_rise;
  logic sck_fall;
  logic cs_fall;
  logic paused;

  sdp_pkg::sdp_state_type state_q, state_d;
  sdp_pkg::sdp_op_type op_q, op_d;
  logic [3:0] cnt_q, cnt_d;
  logic [15:0] sh_q, sh_d;
  logic [15:0] out_q, out_d;
  logic [15:0] rd_word;
  logic [7:0] byte_in;
  logic [15:0] word_in;
  logic [1:0] sel_q, sel_d;
  logic rw_q, rw_d;
  logic first_q, first_d;
  logic armed_q, armed_d;
  logic seen_high_q, seen_high_d;
  logic xfr_q, xfr_d;
  logic so_q, so_d;
  logic so_oe_q, so_oe_d;
  logic [WIPER_W-1:0] wiper_q, wiper_d;
  logic [TAPS-1:0] tap_q, tap_d;
  logic mem_we;
  logic [1:0] mem_raddr;
  logic [WIPER_W-1:0] mem_rdata;
  logic nv_start;
  logic wip_q, wip_d;
  logic [NVW-1:0] nv_cnt_q, nv_cnt_d;
  logic standby_q, standby_d;
  logic active_q, active_d;

  // Two flops on every pin; edge detectors read only the second and third stage
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pins_s1_q <= PINS_RST;
      pins_s2_q <= PINS_RST;
      sck_s3_q <= 1'h0;
      cs_s3_q <= 1'h1;
    end
    else
    begin
      pins_s1_q <= pins;
      pins_s2_q <= pins_s1_q;
      sck_s3_q <= pins_s2_q.sck;
      cs_s3_q <= pins_s2_q.cs_n;
    end
  end

  assign sck_rise = pins_s2_q.sck & ~sck_s3_q;
  assign sck_fall = ~pins_s2_q.sck & sck_s3_q;
  // Sync reset values are not a real high level, so a fall needs a high seen after boot
  assign cs_fall = ~pins_s2_q.cs_n & cs_s3_q & seen_high_q;
  // Pause only counts once a transfer is underway
  assign paused = ~pins_s2_q.hold_n & ~pins_s2_q.cs_n &
                  ((state_q == sdp_pkg::ST_ID) || (state_q == sdp_pkg::ST_INSTR) ||
                   (state_q == sdp_pkg::ST_DATA));
  assign byte_in = {sh_q[6:0], pins_s2_q.si};
  assign word_in = {sh_q[14:0], pins_s2_q.si};
  // Boot reads the default slot, otherwise the select as it is loaded, saving a cycle
  assign mem_raddr = (state_q == sdp_pkg::ST_BOOT) ? `SDP_DEFAULT_SLOT : sel_d;

  // Word shifted out for the current read opcode
  always_comb
  begin
    case (op_q)
      sdp_pkg::OP_RD_WIPER: rd_word = {6'h00, wiper_q};
      sdp_pkg::OP_RD_STORE: rd_word = {6'h00, mem_rdata};
      sdp_pkg::OP_RD_STAT: rd_word = {7'h00, wip_q, 8'h00};
      default: rd_word = 16'h0000;
    endcase
  end

  // Serial sequencer: hold freezes it, deselect ends the frame
  always_comb
  begin
    state_d = state_q;
    op_d = op_q;
    cnt_d = cnt_q;
    sh_d = sh_q;
    out_d = out_q;
    sel_d = sel_q;
    rw_d = rw_q;
    first_d = first_q;
    armed_d = armed_q | cs_fall;
    seen_high_d = seen_high_q | (pins_s2_q.cs_n && state_q != sdp_pkg::ST_BOOT && state_q != sdp_pkg::ST_LOAD);
    xfr_d = 1'h0;
    so_d = so_q;
    wiper_d = wiper_q;
    mem_we = 1'h0;
    nv_start = 1'h0;
    if (!paused)
    begin
      case (state_q)
        sdp_pkg::ST_BOOT:
        begin
          state_d = sdp_pkg::ST_LOAD;
        end
        sdp_pkg::ST_LOAD:
        begin
          wiper_d = mem_rdata;
          state_d = sdp_pkg::ST_IDLE;
        end
        sdp_pkg::ST_IDLE:
        begin
          // A low select left over from power-up does not start a frame
          if ((armed_q || cs_fall) && !pins_s2_q.cs_n)
          begin
            state_d = sdp_pkg::ST_ID;
            cnt_d = 4'h0;
          end
        end
        sdp_pkg::ST_ID:
        begin
          if (sck_rise)
          begin
            sh_d = word_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SDP_BYTE_LAST)
            begin
              cnt_d = 4'h0;
              rw_d = byte_in[`SDP_ID_RW_BIT];
              if ((byte_in[`SDP_ID_TYPE_MSB:`SDP_ID_TYPE_LSB] == `SDP_TYPE_CODE) &&
                  (byte_in[`SDP_ID_ADDR_BIT] == pins_s2_q.address_strap))
              begin
                state_d = sdp_pkg::ST_INSTR;
              end
              else
              begin
                state_d = sdp_pkg::ST_SKIP;
              end
            end
          end
        end
        sdp_pkg::ST_INSTR:
        begin
          if (sck_rise)
          begin
            sh_d = word_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SDP_BYTE_LAST)
            begin
              cnt_d = 4'h0;
              op_d = sdp_pkg::sdp_op_type'(byte_in[`SDP_OP_MSB:`SDP_OP_LSB]);
              sel_d = byte_in[`SDP_SEL_MSB:`SDP_SEL_LSB];
              first_d = 1'h1;
              if (op_d == sdp_pkg::OP_NOP0 || op_d == sdp_pkg::OP_NOP1 || is_read(op_d) != rw_q)
              begin
                state_d = sdp_pkg::ST_SKIP;
              end
              else if (op_d == sdp_pkg::OP_XFR)
              begin
                // Slot read follows the new select at once, so the copy lands next cycle
                xfr_d = 1'h1;
                state_d = sdp_pkg::ST_SKIP;
              end
              else
              begin
                state_d = sdp_pkg::ST_DATA;
              end
            end
          end
        end
        sdp_pkg::ST_DATA:
        begin
          if (is_read(op_q))
          begin
            if (sck_fall)
            begin
              first_d = 1'h0;
              so_d = first_q ? rd_word[15] : out_q[15];
              out_d = first_q ? {rd_word[14:0], 1'h0} : {out_q[14:0], 1'h0};
            end
          end
          else if (sck_rise)
          begin
            sh_d = word_in;
            cnt_d = cnt_q + 4'h1;
            if (cnt_q == `SDP_WORD_LAST)
            begin
              state_d = sdp_pkg::ST_SKIP;
              if (op_q == sdp_pkg::OP_WR_WIPER)
              begin
                wiper_d = word_in[WIPER_W-1:0];
              end
              else if (pins_s2_q.wp_n && !wip_q)
              begin
                mem_we = 1'h1;
                nv_start = 1'h1;
              end
            end
          end
        end
        default:
        begin
          state_d = state_q;
        end
      endcase
    end
    if (xfr_q)
    begin
      wiper_d = mem_rdata;
    end
    // Deselect ends any frame; boot steps finish regardless
    if (pins_s2_q.cs_n && state_q != sdp_pkg::ST_BOOT && state_q != sdp_pkg::ST_LOAD)
    begin
      state_d = sdp_pkg::ST_IDLE;
    end
    // Output driven only once the first read bit is out, never in pause
    so_oe_d = (state_d == sdp_pkg::ST_DATA) && is_read(op_q) && !first_d && !paused &&
              !pins_s2_q.cs_n;
    tap_d = '0;
    tap_d[wiper_d] = 1'h1;
    standby_d = pins_s2_q.cs_n & ~wip_q;
    active_d = ~pins_s2_q.cs_n;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= sdp_pkg::ST_BOOT;
      op_q <= sdp_pkg::OP_NOP0;
      cnt_q <= 4'h0;
      sh_q <= 16'h0000;
      out_q <= 16'h0000;
      sel_q <= 2'h0;
      rw_q <= 1'h0;
      first_q <= 1'h0;
      armed_q <= 1'h0;
      seen_high_q <= 1'h0;
      xfr_q <= 1'h0;
      so_q <= 1'h0;
      so_oe_q <= 1'h0;
      wiper_q <= `SDP_WIPER_RST;
      tap_q <= {{(TAPS-1){1'h0}}, 1'h1};
      standby_q <= 1'h1;
      active_q <= 1'h0;
    end
    else
    begin
      state_q <= state_d;
      op_q <= op_d;
      cnt_q <= cnt_d;
      sh_q <= sh_d;
      out_q <= out_d;
      sel_q <= sel_d;
      rw_q <= rw_d;
      first_q <= first_d;
      armed_q <= armed_d;
      seen_high_q <= seen_high_d;
      xfr_q <= xfr_d;
      so_q <= so_d;
      so_oe_q <= so_oe_d;
      wiper_q <= wiper_d;
      tap_q <= tap_d;
      standby_q <= standby_d;
      active_q <= active_d;
    end
  end

  // Nonvolatile write timer; further stored writes are refused while it runs
  always_comb
  begin
    wip_d = wip_q;
    nv_cnt_d = nv_cnt_q;
    if (nv_start)
    begin
      wip_d = 1'h1;
      nv_cnt_d = '0;
    end
    else if (wip_q)
    begin
      if (nv_cnt_q == NVW'(NV_WRITE_CYCLES - 1))
      begin
        wip_d = 1'h0;
      end
      else
      begin
        nv_cnt_d = nv_cnt_q + NVW'(1);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wip_q <= 1'h0;
      nv_cnt_q <= '0;
    end
    else
    begin
      wip_q <= wip_d;
      nv_cnt_q <= nv_cnt_d;
    end
  end

  sdp_store_mem #(
    .WIDTH(WIPER_W),
    .DEPTH(4),
    .AW(2),
    .INIT(`SDP_STORE_INIT)
  ) u_store (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(sel_q),
    .wdata(word_in[WIPER_W-1:0]),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  assign so = so_q;
  assign so_oe = so_oe_q;
  assign wiper_position_reg = wiper_q;
  assign tap_select = tap_q;
  assign write_pending_flag = wip_q;
  assign standby = standby_q;
  assign active = active_q;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  so_fall_only_a: assert property ($changed(so_q) |-> $past(sck_fall))
    else $error("Serial output changed without a falling clock");
  desel_hiz_a: assert property (pins_s2_q.cs_n |=> !so_oe_q)
    else $error("Serial output driven while deselected");
  hold_hiz_a: assert property (paused |=> !so_oe_q)
    else $error("Serial output driven during pause");
  pause_keeps_a: assert property (paused && !pins_s2_q.cs_n |=> $stable(cnt_q) && $stable(sh_q))
    else $error("Serial position moved during pause");
  addr_mismatch_a: assert property (state_q == sdp_pkg::ST_ID && sck_rise && !paused && !pins_s2_q.cs_n &&
    cnt_q == `SDP_BYTE_LAST && byte_in[`SDP_ID_ADDR_BIT] != pins_s2_q.address_strap
    |=> state_q == sdp_pkg::ST_SKIP)
    else $error("Frame continued with wrong address bit");
  arm_gate_a: assert property (!armed_q |-> state_q inside {sdp_pkg::ST_BOOT, sdp_pkg::ST_LOAD,
    sdp_pkg::ST_IDLE, sdp_pkg::ST_ID})
    else $error("Frame ran before first select fall");
  wp_block_a: assert property ($rose(wip_q) |-> $past(pins_s2_q.wp_n))
    else $error("Stored write started while protected");
  boot_recall_a: assert property (state_q == sdp_pkg::ST_LOAD |=> wiper_q == $past(mem_rdata))
    else $error("Wiper not loaded from default slot");
  tap_onehot_a: assert property ($onehot(tap_q) && tap_q[wiper_q])
    else $error("Tap select not one-hot at wiper value");
  wip_length_a: assert property ($fell(wip_q) |-> $past(nv_cnt_q) == NVW'(NV_WRITE_CYCLES - 1))
    else $error("Stored write time wrong");
  standby_entry_a: assert property (pins_s2_q.cs_n && !wip_q |=> standby_q && !active_q)
    else $error("Standby not entered when idle and deselected");

endmodule

/* File: bench/sdp_host_model.sv */
// Host side of the serial link: mode 0, slow clock, MSB first
module sdp_host_model (
  input wire logic clk,
  input wire logic so,
  input wire logic so_oe,
  output logic cs_n,
  output logic sck,
  output logic si,
  output logic hold_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rd_word;
  logic oe_any;
  logic oe_in_pause;

  // Select starts low, so the first falling edge is under test control
  initial
  begin
    cs_n = 1'b0;
    sck = 1'b0;
    si = 1'b0;
    hold_n = 1'b1;
    rd_word = 32'h0;
    oe_any = 1'b0;
    oe_in_pause = 1'b0;
  end

  // All pin changes land just after a clock edge
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask

  // Each clock level lasts 6 periods, above the 4 the sampler needs
  task automatic shift(input logic [31:0] bits, input int nbits, input int pause_at);
    for (int i = 0; i < nbits; i++)
    begin
      if (i == pause_at)
      begin
        // Let the device take the last falling edge before pausing, or that bit is lost
        step(4);
        hold_n = 1'b0;
        step(8);
        oe_in_pause = so_oe;
        hold_n = 1'b1;
        step(6);
      end
      si = bits[nbits-1-i];
      step(6);
      rd_word = {rd_word[30:0], so};
      oe_any = oe_any | so_oe;
      sck = 1'b1;
      step(6);
      sck = 1'b0;
    end
  endtask

  // Released data line shows the inverse, never a stale value
  task automatic release_bus();
    cs_n = 1'b1;
    si = ~si;
    step(8);
  endtask

  task automatic frame(input logic [31:0] bits, input int nbits, input int pause_at);
    oe_any = 1'b0;
    cs_n = 1'b0;
    step(6);
    shift(bits, nbits, pause_at);
    release_bus();
  endtask
endmodule

/* File: bench/test_spi_digital_pot_interface.sv */
`include "sdp_regs.svh"
module test_spi_digital_pot_interface;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int NV = 400;
  logic clk;
  logic rst_n;
  logic wp_n;
  logic strap;
  logic so;
  logic so_oe;
  logic [9:0] wiper;
  logic [1023:0] tap;
  logic pend;
  logic standby;
  logic active;
  logic host_cs_n;
  logic host_sck;
  logic host_si;
  logic host_hold_n;
  sdp_pkg::sdp_pins_type pins;
  int num_errors;
  int check_count;
  int seed;
  int cnt;
  int bad;
  logic [9:0] v;
  logic [9:0] exp_wiper;
  logic [9:0] exp_slot [4];
  logic [15:0] status;

  assign pins = {host_cs_n, host_sck, host_si, host_hold_n, wp_n, strap};

  sdp_spi_pot #(.NV_WRITE_CYCLES(NV)) u_sdp_spi_pot (.clk(clk), .rst_n(rst_n), .pins(pins), .so(so),
    .so_oe(so_oe), .wiper_position_reg(wiper), .tap_select(tap), .write_pending_flag(pend),
    .standby(standby), .active(active));

  sdp_host_model u_sdp_host_model (.clk(clk), .so(so), .so_oe(so_oe), .cs_n(host_cs_n), .sck(host_sck),
    .si(host_si), .hold_n(host_hold_n));

  always #12.5 clk = ~clk;

  function automatic logic [7:0] id_byte(input logic rw, input logic addr);
    return {`SDP_TYPE_CODE, 2'h0, addr, rw};
  endfunction

  function automatic logic [7:0] ins_byte(input logic [2:0] op, input logic [1:0] sel);
    return {op, 3'h0, sel};
  endfunction

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      num_errors++;
    end
  endtask

  task automatic check_wiper();
    check("wiper", {22'h0, exp_wiper}, {22'h0, wiper});
    check("tap_select", 32'h1, {31'h0, tap === (1024'h1 << exp_wiper)});
  endtask

  task automatic wr(input logic [2:0] op, input logic addr, input logic [1:0] sel, input logic [9:0] val);
    u_sdp_host_model.frame({id_byte(1'b0, addr), ins_byte(op, sel), 6'h0, val}, 32, -1);
  endtask

  task automatic rd(input logic [2:0] op, input logic addr, input logic [1:0] sel, input int pause_at);
    u_sdp_host_model.frame({id_byte(1'b1, addr), ins_byte(op, sel), 16'h0}, 32, pause_at);
  endtask

  // Stored write then status read, counting busy cycles meanwhile
  task automatic nv_write(input logic [1:0] s, input logic [9:0] val);
    cnt = 0;
    bad = 0;
    fork
      begin
        wr(sdp_pkg::OP_WR_STORE, 1'b1, s, val);
        rd(sdp_pkg::OP_RD_STAT, 1'b1, 2'h0, -1);
        status = u_sdp_host_model.rd_word[15:0];
      end
      repeat (1000)
      begin
        @(posedge clk);
        #1;
        if (pend === 1'b1)
          cnt++;
        if (pend === 1'b1 && host_cs_n === 1'b1 && standby !== 1'b0)
          bad++;
      end
    join
  endtask

  task automatic print_verdict();
    if (num_errors == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog sized well above the roughly 30 frames of the run
  initial
  begin
    repeat (40000) @(posedge clk);
    num_errors++;
    print_verdict();
  end

  initial
  begin
    clk = 1'b0;
    rst_n = 1'b0;
    wp_n = 1'b1;
    strap = 1'b1;
    num_errors = 0;
    check_count = 0;
    seed = 32'h93cd;
    exp_wiper = `SDP_STORE_INIT;
    exp_slot = '{default: `SDP_STORE_INIT};
    repeat (3) @(posedge clk);
    #2 rst_n = 1'b1;
    u_sdp_host_model.step(8);
    check_wiper();
    check("idle oe", 32'h0, {31'h0, so_oe});
    // Select was low since reset: no falling edge yet, so this write is ignored
    u_sdp_host_model.shift({id_byte(1'b0, 1'b1), ins_byte(sdp_pkg::OP_WR_WIPER, 2'h0), 16'h0155}, 32, -1);
    u_sdp_host_model.release_bus();
    check_wiper();
    // Wiper writes with both extremes, then random values, each read back
    for (int k = 0; k < 5; k++)
    begin
      v = (k == 0) ? 10'h3ff : (k == 1) ? 10'h000 : 10'($random(seed));
      wr(sdp_pkg::OP_WR_WIPER, 1'b1, 2'(k), v);
      exp_wiper = v;
      check_wiper();
      rd(sdp_pkg::OP_RD_WIPER, 1'b1, 2'h0, -1);
      check("wiper read", {22'h0, v}, {16'h0, u_sdp_host_model.rd_word[15:0]});
    end
    // The two idle opcodes must leave the wiper alone
    for (int op = 0; op < 2; op++)
    begin
      wr(3'(op), 1'b1, 2'h0, ~exp_wiper);
      check_wiper();
    end
    for (int s = 0; s < 4; s++)
    begin
      v = 10'($random(seed));
      nv_write(2'(s), v);
      exp_slot[s] = v;
      check("busy cycles", NV, cnt);
      check("status", 32'h0100, {16'h0, status});
      check("standby in write", 32'h0, bad);
    end
    check("standby", 32'h1, {31'h0, standby & ~active});
    for (int s = 0; s < 4; s++)
    begin
      rd(sdp_pkg::OP_RD_STORE, 1'b1, 2'(s), -1);
      check("slot read", {22'h0, exp_slot[s]}, {16'h0, u_sdp_host_model.rd_word[15:0]});
    end
    // Protected store write is dropped without a busy period
    wp_n = 1'b0;
    nv_write(2'h1, ~exp_slot[1]);
    check("protected busy", 32'h0, cnt);
    check("protected status", 32'h0, {16'h0, status});
    rd(sdp_pkg::OP_RD_STORE, 1'b1, 2'h1, -1);
    check("protected slot", {22'h0, exp_slot[1]}, {16'h0, u_sdp_host_model.rd_word[15:0]});
    wp_n = 1'b1;
    // Transfer is only two bytes long
    u_sdp_host_model.frame({16'h0, id_byte(1'b0, 1'b1), ins_byte(sdp_pkg::OP_XFR, 2'h3)}, 16, -1);
    exp_wiper = exp_slot[3];
    check_wiper();
    // Address bit against the strap, both ways
    wr(sdp_pkg::OP_WR_WIPER, 1'b0, 2'h0, ~exp_wiper);
    check_wiper();
    rd(sdp_pkg::OP_RD_WIPER, 1'b0, 2'h0, -1);
    check("foreign read oe", 32'h0, {31'h0, u_sdp_host_model.oe_any});
    strap = 1'b0;
    v = 10'($random(seed));
    wr(sdp_pkg::OP_WR_WIPER, 1'b0, 2'h0, v);
    exp_wiper = v;
    check_wiper();
    // Pause in the middle of the read data
    rd(sdp_pkg::OP_RD_WIPER, 1'b0, 2'h0, 20);
    check("paused read", {22'h0, v}, {16'h0, u_sdp_host_model.rd_word[15:0]});
    check("pause oe", 32'h0, {31'h0, u_sdp_host_model.oe_in_pause});
    check("deselect oe", 32'h0, {31'h0, so_oe});
    print_verdict();
  end
endmodule
